// *** mem_ctrl_pkg.sv ***
// shared constants, types and helper functions of the memory controller
// Notes on behaviour
// - program flash is 128 pages of 1kB
// - single page erase/program while SRAM runs
// - look-ahead buffer prefetches next flash word
// - three info pages of 1kB each
// - first two info pages read-only to software
// - third info page writable by software
// - SRAM takes word, half-word and byte accesses
// - SRAM path runs at full bus clock
// - SECDED per SRAM word, correct single, flag double
// - status shows corrected single-bit error
// - enabled interrupt on each single-bit error
// - double-bit error can raise an interrupt
// - partial SRAM writes are read-merge-write, multi-cycle
// - four levels; levels 2 and 3 disable debug
// - 64 regions, each read or write protectable
package mem_ctrl_pkg;

  // ****************
  // memory map
  // ****************
  localparam logic [31:0] MAIN_BASE = 32'h0000_0000;
  localparam logic [31:0] INFO_BASE = 32'h0010_0000;
  localparam logic [31:0] SRAM_BASE = 32'h2000_0000;
  localparam int MAIN_PAGES = 128;
  localparam int PAGE_WORDS = 256;
  localparam int INFO_PAGES = 3;
  localparam int FLASH_WORDS = (MAIN_PAGES + INFO_PAGES) * PAGE_WORDS;
  localparam int SRAM_WORDS = 8192;
  localparam logic [15:0] INFO_IDX_BASE = 16'h8000;
  localparam logic [1:0] USER_INFO_PAGE = 2'h2;

  // ****************
  // register offsets and fields
  // ****************
  localparam logic [7:0] REG_STATUS = 8'h00;
  localparam logic [7:0] REG_IRQ_MASK = 8'h04;
  localparam logic [7:0] REG_PROT_LEVEL = 8'h08;
  localparam logic [7:0] REG_RD_PROT_LO = 8'h0c;
  localparam logic [7:0] REG_RD_PROT_HI = 8'h10;
  localparam logic [7:0] REG_WR_PROT_LO = 8'h14;
  localparam logic [7:0] REG_WR_PROT_HI = 8'h18;
  localparam logic [7:0] REG_FLASH_ADDR = 8'h1c;
  localparam logic [7:0] REG_FLASH_DATA = 8'h20;
  localparam logic [7:0] REG_FLASH_CMD = 8'h24;
  localparam logic [7:0] REG_ERR_ADDR = 8'h28;
  localparam int EV_SEC = 0;
  localparam int EV_DED = 1;
  localparam int EV_PROT = 2;
  localparam int EV_DONE = 3;
  localparam logic [1:0] CMD_PROG = 2'h1;
  localparam logic [1:0] CMD_ERASE = 2'h2;
  localparam logic [1:0] LVL_OPEN = 2'h0;
  localparam logic [1:0] LVL_NO_DEBUG = 2'h2;
  localparam logic [1:0] LVL_FUSED = 2'h3;
  localparam logic [1:0] SIZE_BYTE = 2'h0;
  localparam logic [1:0] SIZE_HALF = 2'h1;
  localparam logic [1:0] SIZE_WORD = 2'h2;

  // ****************
  // timing
  // ****************
  localparam int CLK_MHZ = 200;
  localparam int FLASH_READ_NS = 40;
  localparam int FLASH_READ_CYC = (FLASH_READ_NS * CLK_MHZ + 999) / 1000;
  localparam int FLASH_PROG_US = 30;
  localparam int FLASH_PROG_CYC_DFLT = FLASH_PROG_US * CLK_MHZ;
  localparam int FLASH_ERASE_MS = 2;
  localparam int FLASH_ERASE_CYC_DFLT = FLASH_ERASE_MS * CLK_MHZ * 1000;

  // ****************
  // carriers
  // ****************
  typedef struct packed {
    logic valid;
    logic write;
    logic [1:0] size;
    logic [31:0] addr;
    logic [31:0] wdata;
  } mem_req_t;

  typedef struct packed {
    logic valid;
    logic error;
    logic [31:0] rdata;
  } mem_rsp_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [31:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic [31:0] data;
    logic single;
    logic double;
  } ecc_res_t;

  // ****************
  // decode helpers
  // ****************
  function automatic logic in_main(input logic [31:0] a);
    return a[31:17] == MAIN_BASE[31:17];
  endfunction

  function automatic logic in_info(input logic [31:0] a);
    return (a[31:12] == INFO_BASE[31:12]) && (a[11:10] != 2'h3);
  endfunction

  function automatic logic in_sram(input logic [31:0] a);
    return a[31:15] == SRAM_BASE[31:15];
  endfunction

  function automatic logic [5:0] region_of(input logic [31:0] a);
    return a[16:11];
  endfunction

  function automatic logic [15:0] flash_index(input logic [31:0] a);
    if (a[31:20] == INFO_BASE[31:20]) begin
      return INFO_IDX_BASE | 16'(a[11:2]);
    end
    return {1'b0, a[16:2]};
  endfunction

  // check bits: hamming over positions 3..38, then overall parity
  function automatic logic [6:0] ecc_chk(input logic [31:0] d);
    logic [6:0] c;
    int n;
    c = '0;
    n = 0;
    for (int p = 3; p < 39; p++) begin
      if ((p & (p - 1)) != 0) begin
        if (d[n]) begin
          c[5:0] = c[5:0] ^ 6'(p);
        end
        n++;
      end
    end
    c[6] = ^{d, c[5:0]};
    return c;
  endfunction

  function automatic ecc_res_t ecc_fix(input logic [38:0] cw);
    ecc_res_t r;
    logic [5:0] syn;
    logic odd;
    int n;
    r.data = cw[31:0];
    syn = 6'(ecc_chk(cw[31:0])) ^ cw[37:32];
    odd = ^cw;
    n = 0;
    r.single = odd;
    r.double = (syn != 6'h00) && !odd;
    for (int p = 3; p < 39; p++) begin
      if ((p & (p - 1)) != 0) begin
        if (odd && (6'(p) == syn)) begin
          r.data[n] = ~r.data[n];
        end
        n++;
      end
    end
    return r;
  endfunction

  // lane-aligned merge of a partial write into the old word
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [1:0] size, input logic [1:0] lane);
    logic [31:0] m;
    case (size)
      SIZE_BYTE: m = 32'h0000_00ff << {lane, 3'h0};
      SIZE_HALF: m = 32'h0000_ffff << {lane[1], 4'h0};
      default: m = 32'hffff_ffff;
    endcase
    return (old & ~m) | (wd & m);
  endfunction

endpackage

// *** memory_controller_ecc_protect.sv ***
// memory controller: flash with look-ahead, info pages, SECDED SRAM, code protection
`timescale 1ns/1ps
module memory_controller_ecc_protect
  import mem_ctrl_pkg::*;
#(
  parameter int PROG_CYC = FLASH_PROG_CYC_DFLT,
  parameter int ERASE_CYC = FLASH_ERASE_CYC_DFLT
) (
  // clock and resets
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  input wire logic pwr_on_rst_in,
  // system bus memory port
  input wire mem_req_t mem_req_in,
  output mem_rsp_t mem_rsp_out,
  output logic mem_busy_out,
  // register port
  input wire reg_req_t reg_req_in,
  output logic [31:0] reg_rdata_out,
  // interrupt and debug
  output logic irq_out,
  output logic debug_enable_out
);

  // ****************
  // state
  // ****************
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_SRAM = 3'b010,
    ST_FLASH = 3'b100
  } mc_state_t;

  typedef enum logic [2:0] {
    FOP_IDLE = 3'b001,
    FOP_ERASE = 3'b010,
    FOP_WAIT = 3'b100
  } fop_t;

  typedef struct packed {
    mc_state_t st;
    fop_t fop;
    logic [31:0] addr;
    logic [31:0] wdata;
    logic [1:0] size;
    logic write;
    logic [19:0] fcnt;
    logic [15:0] fidx;
    logic [3:0] rcnt;
    logic pf_valid;
    logic [3:0] pf_cnt;
    logic [31:0] pf_addr;
    logic [31:0] pf_data;
    logic [3:0] status;
    logic [3:0] mask;
    logic [1:0] level;
    logic fused;
    logic [63:0] rd_prot;
    logic [63:0] wr_prot;
    logic [31:0] fl_addr;
    logic [31:0] fl_data;
    logic [31:0] err_addr;
    mem_rsp_t rsp;
    logic busy;
    logic [31:0] rdata;
    logic irq;
    logic dbg_en;
  } mc_regs_t;

  localparam logic [3:0] FLASH_WAIT_LOAD = 4'(FLASH_READ_CYC - 2);
  localparam logic [3:0] PF_LOAD = 4'(FLASH_READ_CYC);

  mc_regs_t s;
  mc_regs_t next_s;
  logic [38:0] sram_mem [SRAM_WORDS];
  logic [31:0] flash_mem [FLASH_WORDS];
  logic sram_we;
  logic [12:0] sram_widx;
  logic [38:0] sram_wdata;
  logic flash_we;
  logic [15:0] flash_widx;
  logic [31:0] flash_wdata;
  logic [3:0] ev;
  logic [3:0] clr;
  logic [1:0] eff_level;
  logic acc;
  logic rd_denied;
  logic pf_hit;
  logic cmd_denied;
  ecc_res_t dec;
  logic [31:0] merged;

  // array read ports and request decode
  assign eff_level = s.fused ? LVL_FUSED : s.level;
  assign acc = mem_req_in.valid && (s.st == ST_IDLE);
  assign rd_denied = in_main(mem_req_in.addr) && (eff_level != LVL_OPEN) &&
                     s.rd_prot[region_of(mem_req_in.addr)];
  assign pf_hit = s.pf_valid && (s.pf_addr == mem_req_in.addr);
  assign dec = ecc_fix(sram_mem[s.addr[14:2]]);
  assign merged = merge(dec.data, s.wdata, s.size, s.addr[1:0]);
  // info pages one and two never accept flash commands
  assign cmd_denied = in_main(s.fl_addr) ?
                      ((eff_level != LVL_OPEN) && s.wr_prot[region_of(s.fl_addr)]) :
                      (!in_info(s.fl_addr) || (s.fl_addr[11:10] != USER_INFO_PAGE));

  // ****************
  // next-state logic
  // ****************
  always_comb begin
    next_s = s;
    next_s.rsp = '0;
    next_s.rdata = '0;
    sram_we = 1'b0;
    sram_widx = '0;
    sram_wdata = '0;
    flash_we = 1'b0;
    flash_widx = '0;
    flash_wdata = '0;
    ev = '0;
    clr = '0;

    // register reads, data valid only in the following cycle
    if (reg_req_in.rd) begin
      case (reg_req_in.addr)
        REG_STATUS: next_s.rdata = {28'h0, s.status};
        REG_IRQ_MASK: next_s.rdata = {28'h0, s.mask};
        REG_PROT_LEVEL: next_s.rdata = {30'h0, eff_level};
        REG_RD_PROT_LO: next_s.rdata = s.rd_prot[31:0];
        REG_RD_PROT_HI: next_s.rdata = s.rd_prot[63:32];
        REG_WR_PROT_LO: next_s.rdata = s.wr_prot[31:0];
        REG_WR_PROT_HI: next_s.rdata = s.wr_prot[63:32];
        REG_FLASH_ADDR: next_s.rdata = s.fl_addr;
        REG_FLASH_DATA: next_s.rdata = s.fl_data;
        REG_FLASH_CMD: next_s.rdata = {31'h0, s.fop != FOP_IDLE};
        REG_ERR_ADDR: next_s.rdata = s.err_addr;
        default: next_s.rdata = '0;
      endcase
    end

    // flash operation engine, runs beside bus traffic
    case (s.fop)
      FOP_IDLE: begin
        next_s.fcnt = '0;
      end
      FOP_ERASE: begin
        flash_we = 1'b1;
        flash_widx = s.fidx;
        flash_wdata = 32'hffff_ffff;
        next_s.fidx = s.fidx + 16'h0001;
        if (s.fcnt == 20'h0) begin
          next_s.fop = FOP_WAIT;
          next_s.fcnt = 20'(ERASE_CYC);
        end else begin
          next_s.fcnt = s.fcnt - 20'h1;
        end
      end
      FOP_WAIT: begin
        if (s.fcnt <= 20'h1) begin
          next_s.fop = FOP_IDLE;
          ev[EV_DONE] = 1'b1;
        end else begin
          next_s.fcnt = s.fcnt - 20'h1;
        end
      end
      default: next_s.fop = FOP_IDLE;
    endcase

    // register writes
    if (reg_req_in.wr) begin
      case (reg_req_in.addr)
        REG_STATUS: clr = reg_req_in.wdata[3:0];
        REG_IRQ_MASK: next_s.mask = reg_req_in.wdata[3:0];
        REG_PROT_LEVEL: begin
          // once fused, any lowering request is ignored
          if (!s.fused) begin
            next_s.level = reg_req_in.wdata[1:0];
            next_s.fused = reg_req_in.wdata[1:0] == LVL_FUSED;
          end
        end
        REG_RD_PROT_LO: next_s.rd_prot[31:0] = reg_req_in.wdata;
        REG_RD_PROT_HI: next_s.rd_prot[63:32] = reg_req_in.wdata;
        REG_WR_PROT_LO: next_s.wr_prot[31:0] = reg_req_in.wdata;
        REG_WR_PROT_HI: next_s.wr_prot[63:32] = reg_req_in.wdata;
        REG_FLASH_ADDR: next_s.fl_addr = reg_req_in.wdata;
        REG_FLASH_DATA: next_s.fl_data = reg_req_in.wdata;
        REG_FLASH_CMD: begin
          if (s.fop == FOP_IDLE) begin
            if (cmd_denied) begin
              ev[EV_PROT] = 1'b1;
            end else if (reg_req_in.wdata[1:0] == CMD_PROG) begin
              flash_we = 1'b1;
              flash_widx = flash_index(s.fl_addr);
              flash_wdata = s.fl_data;
              next_s.fop = FOP_WAIT;
              next_s.fcnt = 20'(PROG_CYC);
              next_s.pf_valid = 1'b0;
            end else if (reg_req_in.wdata[1:0] == CMD_ERASE) begin
              next_s.fop = FOP_ERASE;
              next_s.fidx = flash_index(s.fl_addr) & 16'hff00;
              next_s.fcnt = 20'(PAGE_WORDS - 1);
              next_s.pf_valid = 1'b0;
            end
          end
        end
        default: next_s.mask = s.mask;
      endcase
    end

    // look-ahead buffer fill
    if (s.pf_cnt != 4'h0) begin
      next_s.pf_cnt = s.pf_cnt - 4'h1;
      if (s.pf_cnt == 4'h1) begin
        next_s.pf_data = flash_mem[flash_index(s.pf_addr)];
        // a word fetched while flash is being changed may be stale
        next_s.pf_valid = (next_s.fop == FOP_IDLE);
      end
    end

    // bus access sequencer
    case (s.st)
      ST_IDLE: begin
        if (mem_req_in.valid) begin
          next_s.addr = mem_req_in.addr;
          next_s.wdata = mem_req_in.wdata;
          next_s.size = mem_req_in.size;
          next_s.write = mem_req_in.write;
          if (in_sram(mem_req_in.addr)) begin
            if (mem_req_in.write && (mem_req_in.size == SIZE_WORD)) begin
              sram_we = 1'b1;
              sram_widx = mem_req_in.addr[14:2];
              sram_wdata = {ecc_chk(mem_req_in.wdata), mem_req_in.wdata};
              next_s.rsp.valid = 1'b1;
            end else begin
              next_s.st = ST_SRAM;
              next_s.busy = 1'b1;
            end
          end else if (in_main(mem_req_in.addr) || in_info(mem_req_in.addr)) begin
            if (mem_req_in.write || (s.fop != FOP_IDLE) || rd_denied) begin
              next_s.rsp.valid = 1'b1;
              next_s.rsp.error = 1'b1;
              ev[EV_PROT] = ev[EV_PROT] | rd_denied;  // keep a same-cycle denied command
            end else if (pf_hit) begin
              next_s.rsp.valid = 1'b1;
              next_s.rsp.rdata = s.pf_data;
              next_s.pf_valid = 1'b0;
              next_s.pf_addr = mem_req_in.addr + 32'h4;
              next_s.pf_cnt = PF_LOAD;
            end else begin
              next_s.st = ST_FLASH;
              next_s.busy = 1'b1;
              next_s.rcnt = FLASH_WAIT_LOAD;
            end
          end else begin
            next_s.rsp.valid = 1'b1;
            next_s.rsp.error = 1'b1;
          end
        end
      end
      ST_SRAM: begin
        ev[EV_SEC] = dec.single;
        ev[EV_DED] = dec.double;
        if (dec.single || dec.double) begin
          next_s.err_addr = s.addr;
        end
        next_s.rsp.valid = 1'b1;
        next_s.rsp.error = dec.double;
        if (!s.write) begin
          next_s.rsp.rdata = dec.data;
        end else if (!dec.double) begin
          sram_we = 1'b1;
          sram_widx = s.addr[14:2];
          sram_wdata = {ecc_chk(merged), merged};
        end
        next_s.st = ST_IDLE;
        next_s.busy = 1'b0;
      end
      ST_FLASH: begin
        if (s.rcnt == 4'h0) begin
          next_s.rsp.valid = 1'b1;
          next_s.rsp.rdata = flash_mem[flash_index(s.addr)];
          next_s.pf_valid = 1'b0;
          next_s.pf_addr = s.addr + 32'h4;
          next_s.pf_cnt = PF_LOAD;
          next_s.st = ST_IDLE;
          next_s.busy = 1'b0;
        end else begin
          next_s.rcnt = s.rcnt - 4'h1;
        end
      end
      default: begin
        next_s.st = ST_IDLE;
        next_s.busy = 1'b0;
      end
    endcase

    // sticky status: a new event beats a same-cycle clear
    next_s.status = (s.status & ~clr) | ev;
    next_s.irq = |(next_s.status & next_s.mask);
    next_s.dbg_en = !next_s.fused && (next_s.level < LVL_NO_DEBUG);
  end

  // ****************
  // registers
  // ****************
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in || pwr_on_rst_in) begin
      s <= '0;
      s.st <= ST_IDLE;
      s.fop <= FOP_IDLE;
      s.fused <= s.fused && !pwr_on_rst_in;
      s.dbg_en <= pwr_on_rst_in || !s.fused;
    end else begin
      s <= next_s;
    end
  end

  // storage arrays, no reset
  always_ff @(posedge core_clk_in) begin
    if (sram_we) begin
      sram_mem[sram_widx] <= sram_wdata;
    end
    if (flash_we) begin
      flash_mem[flash_widx] <= flash_wdata;
    end
  end

  // outputs straight from flops
  assign mem_rsp_out = s.rsp;
  assign mem_busy_out = s.busy;
  assign reg_rdata_out = s.rdata;
  assign irq_out = s.irq;
  assign debug_enable_out = s.dbg_en;

  // ****************
  // checks
  // ****************
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (sys_rst_in || pwr_on_rst_in);

  property p_word_write;
    acc && in_sram(mem_req_in.addr) && mem_req_in.write && (mem_req_in.size == SIZE_WORD)
      |=> mem_rsp_out.valid && !mem_rsp_out.error && !mem_busy_out;
  endproperty
  a_word_write: assert property (p_word_write) else $error("word write not done in one cycle");

  property p_rmw_len;
    acc && in_sram(mem_req_in.addr) && mem_req_in.write && (mem_req_in.size != SIZE_WORD)
      |=> mem_busy_out && !mem_rsp_out.valid ##1 mem_rsp_out.valid && !mem_busy_out;
  endproperty
  a_rmw_len: assert property (p_rmw_len) else $error("partial write not two cycles");

  property p_pf_hit;
    acc && pf_hit && !rd_denied && !mem_req_in.write && (s.fop == FOP_IDLE)
      && in_main(mem_req_in.addr) |=> mem_rsp_out.valid && (mem_rsp_out.rdata == $past(s.pf_data));
  endproperty
  a_pf_hit: assert property (p_pf_hit) else $error("look-ahead hit not served next cycle");

  property p_miss_latency;
    acc && !pf_hit && !rd_denied && !mem_req_in.write && (s.fop == FOP_IDLE)
      && in_main(mem_req_in.addr) |=> !mem_rsp_out.valid [*7] ##1 mem_rsp_out.valid;
  endproperty
  a_miss_latency: assert property (p_miss_latency) else $error("flash miss latency wrong");

  property p_prot_read;
    acc && rd_denied |=> mem_rsp_out.valid && mem_rsp_out.error && s.status[EV_PROT];
  endproperty
  a_prot_read: assert property (p_prot_read) else $error("protected read not refused");

  property p_fused_sticky;
    (eff_level == LVL_FUSED) |=> (eff_level == LVL_FUSED) && !debug_enable_out;
  endproperty
  a_fused_sticky: assert property (p_fused_sticky) else $error("fused level was lowered");

  property p_debug_off;
    (eff_level >= LVL_NO_DEBUG) |-> !debug_enable_out;
  endproperty
  a_debug_off: assert property (p_debug_off) else $error("debug enabled at level two or up");

  property p_sec_irq;
    ev[EV_SEC] && s.mask[EV_SEC] && !(reg_req_in.wr && (reg_req_in.addr == REG_IRQ_MASK))
      |=> s.status[EV_SEC] && irq_out;
  endproperty
  a_sec_irq: assert property (p_sec_irq) else $error("single error not flagged");

  property p_info_ro;
    reg_req_in.wr && (reg_req_in.addr == REG_FLASH_CMD) && (s.fop == FOP_IDLE)
      && in_info(s.fl_addr) && (s.fl_addr[11:10] != USER_INFO_PAGE)
      |=> s.status[EV_PROT] && (s.fop == FOP_IDLE);
  endproperty
  a_info_ro: assert property (p_info_ro) else $error("factory info page was modified");

endmodule

// *** core_bus_model.sv ***
// processor-side master model for the memory port
`timescale 1ns/1ps
module core_bus_model
  import mem_ctrl_pkg::*;
(
  // clock
  input wire logic clk_in,
  // memory port
  input wire mem_rsp_t rsp_in,
  input wire logic busy_in,
  output mem_req_t req_out
);
  initial req_out = '0;

  // hold the request until taken, release it, then wait for the answer
  task automatic access(input logic w, input logic [1:0] s, input logic [31:0] a,
                        input logic [31:0] d, output mem_rsp_t r, output int n);
    req_out <= '{valid: 1'b1, write: w, size: s, addr: a, wdata: d};
    @(posedge clk_in);
    while (busy_in) @(posedge clk_in);
    // released lines show inverted values, never the last request
    req_out <= '{valid: 1'b0, write: ~w, size: ~s, addr: ~a, wdata: ~d};
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (!rsp_in.valid && n < 40);
    r = rsp_in;
  endtask
endmodule

// *** tb.sv ***
// self-checking testbench of the memory controller
`timescale 1ns/1ps
module tb
  import mem_ctrl_pkg::*;
;
  logic clk, rst, por, busy, irq, dbg;
  mem_req_t req;
  mem_rsp_t rsp, r;
  reg_req_t rq;
  logic [31:0] rdat, v;
  int num_errors = 0;
  int compares = 0;
  int n;

  memory_controller_ecc_protect #(.PROG_CYC(20), .ERASE_CYC(20)) uut (
    .core_clk_in(clk), .sys_rst_in(rst), .pwr_on_rst_in(por), .mem_req_in(req),
    .mem_rsp_out(rsp), .mem_busy_out(busy), .reg_req_in(rq), .reg_rdata_out(rdat),
    .irq_out(irq), .debug_enable_out(dbg));
  core_bus_model core (.clk_in(clk), .rsp_in(rsp), .busy_in(busy), .req_out(req));

  // 200 mhz clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // ****************
  // tasks
  // ****************
  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic complete_run();
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    rq <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    rq <= '0;
    @(posedge clk);
  endtask

  // data stands only in the cycle after the strobe
  task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
    rq <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
    @(posedge clk);
    rq <= '0;
    @(posedge clk);
    d = rdat;
  endtask

  task automatic acc(input logic w, input logic [1:0] s, input logic [31:0] a,
                     input logic [31:0] d, input logic e);
    core.access(w, s, a, d, r, n);
    // an answer that never came counts as a mismatch
    chk("answer valid", 32'h1, {31'h0, r.valid});
    chk("bus error", {31'h0, e}, {31'h0, r.error});
  endtask

  task automatic rd_chk(input logic [31:0] a, input logic [31:0] e, input int c);
    acc(1'b0, SIZE_WORD, a, 32'h0, 1'b0);
    chk("read data", e, r.rdata);
    if (c > 0) chk("answer cycles", 32'(c), 32'(n));
  endtask

  task automatic fwait();
    v = 32'h1;
    for (int i = 0; i < 400 && v[0] !== 1'b0; i++) reg_rd(REG_FLASH_CMD, v);
    chk("flash idle", 32'h0, v);
  endtask

  task automatic prog(input logic [31:0] a, input logic [31:0] d);
    reg_wr(REG_FLASH_ADDR, a);
    reg_wr(REG_FLASH_DATA, d);
    reg_wr(REG_FLASH_CMD, 32'(CMD_PROG));
  endtask

  // watchdog
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    complete_run();
  end

  // ****************
  // tests
  // ****************
  initial begin
    rq = '0;
    rst = 1'b1;
    por = 1'b1;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    por <= 1'b0;
    chk("debug", 32'h1, 32'(dbg));
    reg_rd(REG_PROT_LEVEL, v);
    chk("level", 32'h0, v);
    reg_rd(8'h3c, v);
    chk("unmapped reg", 32'h0, v);
    // sram word, byte and half-word writes
    acc(1'b1, SIZE_WORD, SRAM_BASE + 32'h8, 32'h1122_3344, 1'b0);
    chk("word write cycles", 32'h1, 32'(n));
    acc(1'b1, SIZE_BYTE, SRAM_BASE + 32'h9, 32'h0000_aa00, 1'b0);
    chk("byte write cycles", 32'h2, 32'(n));
    acc(1'b1, SIZE_HALF, SRAM_BASE + 32'ha, 32'hbeef_0000, 1'b0);
    chk("half write cycles", 32'h2, 32'(n));
    rd_chk(SRAM_BASE + 32'h8, 32'hbeef_aa44, 2);
    acc(1'b1, SIZE_WORD, SRAM_BASE + 32'h7ffc, 32'h5a5a_0f0f, 1'b0);
    rd_chk(SRAM_BASE + 32'h7ffc, 32'h5a5a_0f0f, 2);
    acc(1'b0, SIZE_WORD, SRAM_BASE + 32'h8000, 32'h0, 1'b1);
    acc(1'b1, SIZE_WORD, 32'h0000_1000, 32'h1, 1'b1);
    // flash program, busy flash and running sram
    prog(32'h0000_1000, 32'hcafe_0001);
    acc(1'b0, SIZE_WORD, 32'h0000_1000, 32'h0, 1'b1);
    rd_chk(SRAM_BASE + 32'h8, 32'hbeef_aa44, 2);
    fwait();
    prog(32'h0000_1004, 32'hcafe_0002);
    fwait();
    rd_chk(32'h0000_1000, 32'hcafe_0001, 8);
    // let the look-ahead fetch of the next word finish
    repeat (8) @(posedge clk);
    rd_chk(32'h0000_1004, 32'hcafe_0002, 1);
    prog(32'h0001_fffc, 32'h7777_0127);
    fwait();
    rd_chk(32'h0001_fffc, 32'h7777_0127, 0);
    reg_wr(REG_FLASH_ADDR, 32'h0000_1000);
    reg_wr(REG_FLASH_CMD, 32'(CMD_ERASE));
    fwait();
    rd_chk(32'h0000_1004, 32'hffff_ffff, 0);
    // info pages
    prog(INFO_BASE + 32'h800, 32'h0bad_f00d);
    fwait();
    rd_chk(INFO_BASE + 32'h800, 32'h0bad_f00d, 0);
    acc(1'b0, SIZE_WORD, INFO_BASE + 32'hc00, 32'h0, 1'b1);
    reg_wr(REG_STATUS, 32'hf);
    prog(INFO_BASE, 32'h1234_5678);
    reg_rd(REG_STATUS, v);
    chk("fault bit", 32'h1, 32'(v[EV_PROT]));
    // region protection and interrupt
    reg_wr(REG_PROT_LEVEL, 32'h1);
    reg_wr(REG_RD_PROT_LO, 32'h1);
    reg_wr(REG_STATUS, 32'hf);
    reg_wr(REG_IRQ_MASK, 32'h4);
    acc(1'b0, SIZE_WORD, 32'h0000_0000, 32'h0, 1'b1);
    rd_chk(32'h0000_1000, 32'hffff_ffff, 0);
    reg_rd(REG_STATUS, v);
    chk("status", 32'h4, v);
    @(posedge clk);
    chk("rdata idle", 32'h0, rdat);
    chk("irq", 32'h1, 32'(irq));
    reg_wr(REG_IRQ_MASK, 32'h0);
    reg_rd(REG_STATUS, v);
    chk("masked irq", 32'h0, 32'(irq));
    reg_wr(REG_IRQ_MASK, 32'h4);
    reg_wr(REG_STATUS, 32'h4);
    reg_rd(REG_STATUS, v);
    chk("cleared status", 32'h0, v);
    chk("cleared irq", 32'h0, 32'(irq));
    reg_wr(REG_WR_PROT_LO, 32'h2);
    prog(32'h0000_0800, 32'h1);
    reg_rd(REG_STATUS, v);
    chk("write fault", 32'h1, 32'(v[EV_PROT]));
    reg_wr(REG_PROT_LEVEL, 32'h0);
    acc(1'b0, SIZE_WORD, 32'h0000_0000, 32'h0, 1'b0);
    // debug port per level
    reg_wr(REG_PROT_LEVEL, 32'(LVL_NO_DEBUG));
    reg_rd(REG_PROT_LEVEL, v);
    chk("debug level 2", 32'h0, 32'(dbg));
    reg_wr(REG_PROT_LEVEL, 32'h1);
    reg_rd(REG_PROT_LEVEL, v);
    chk("debug level 1", 32'h1, 32'(dbg));
    reg_wr(REG_PROT_LEVEL, 32'(LVL_FUSED));
    reg_wr(REG_PROT_LEVEL, 32'(LVL_OPEN));
    reg_rd(REG_PROT_LEVEL, v);
    chk("fused level", 32'h3, v);
    chk("debug fused", 32'h0, 32'(dbg));
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    chk("debug after reset", 32'h0, 32'(dbg));
    por <= 1'b1;
    @(posedge clk);
    por <= 1'b0;
    repeat (2) @(posedge clk);
    chk("debug after power on", 32'h1, 32'(dbg));
    complete_run();
  end
endmodule
